// >>> spll_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "spll_regs.svh"
// Behaviour
// R01: Port config writes apply without update strobe
// R02: Bit 4 selects long instruction phase
// R03: Bit 5 soft reset restores other registers
// R04: Soft reset bit clears itself afterwards
// R05: Bit 6 selects LSB-first order everywhere
// R06: Bit 7 tri-states serial out pin
// R07: Swallow count in bits 5:0, address 4
// R08: Main count split across addresses 5, 6
// R09: Address 7 bit 2 enables loss detect
// R10: Delay 3/6/12/24 phase detector cycles after lock
// R11: Address 8 bits 1:0 set pump mode
module spll_ctrl (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_wr_stb,
    input wire logic [12:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic [12:0] i_rd_addr,
    input wire logic i_pd_clk,
    input wire logic i_lock,
    input wire logic i_sdo_req,
    input wire logic i_sdo_bit,
    output logic [7:0] o_rd_data,
    output logic [4:0] o_instr_len,
    output logic o_lsb_first,
    output logic o_serial_out_pin,
    output logic o_serial_out_pin_oe,
    output logic o_sdio_out,
    output logic o_sdio_oe,
    output spll_pkg::pll_cfg_type o_pll_cfg,
    output logic o_ref_loss_detect_en,
    output logic o_soft_rst_busy
);
    logic [7:0] cfg_r;
    logic [7:0] swallow_r;
    logic [7:0] main_hi_r;
    logic [7:0] main_lo_r;
    logic [7:0] ref_loss_r;
    logic [7:0] pump_r;
    logic srst_r;
    logic [7:0] rd_nxt;
    logic pd_rise;
    logic lock_sync;
    logic lock_seen_r;
    logic [4:0] dly_cnt_r;
    logic [4:0] dly_target;
    logic det_en_r;
    spll_pkg::port_cfg_type port_r;

    // Phase detector clock and lock arrive from outside this domain
    edge_sync u_pd_sync (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_async(i_pd_clk),
        .o_level(),
        .o_rise(pd_rise),
        .o_fall()
    );
    edge_sync u_lock_sync (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_async(i_lock),
        .o_level(lock_sync),
        .o_rise(),
        .o_fall()
    );

    // Port configuration register, applied at once on write
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg_r <= `CFG_RESET;
        end else if (i_wr_stb && i_wr_addr == `ADDR_PORT_CFG) begin
            cfg_r <= {i_wr_data[7:4], 4'h0}; // see R01
        end else if (srst_r) begin
            cfg_r[`CFG_SRST_BIT] <= 1'b0; // see R04
        end
    end

    // Port config holds only its used bits and keeps all but the reset bit through soft reset
    cfg_low_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R01
        cfg_r[3:0] == 4'h0)
        else $error("port config unused bits set");
    cfg_keep_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R03
        (srst_r && !(i_wr_stb && i_wr_addr == `ADDR_PORT_CFG))
        |=> (cfg_r[7:6] == $past(cfg_r[7:6]) && cfg_r[4] == $past(cfg_r[4])))
        else $error("soft reset changed port config");

    // Soft reset pulse follows a write of the reset bit
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            srst_r <= 1'b0;
        end else begin
            srst_r <= cfg_r[`CFG_SRST_BIT] & ~srst_r; // see R03
        end
    end

    // Soft reset starts on the bit and lasts one cycle
    srst_start_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R03
        (cfg_r[`CFG_SRST_BIT] && !srst_r) |=> srst_r)
        else $error("soft reset did not start");
    srst_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R04
        srst_r |=> !srst_r)
        else $error("soft reset pulse too long");

    // PLL settings, restored by soft reset
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            swallow_r <= `SWALLOW_RESET;
            main_hi_r <= `MAIN_HI_RESET;
            main_lo_r <= `MAIN_LO_RESET;
            ref_loss_r <= `REF_LOSS_RESET;
            pump_r <= `PUMP_RESET;
        end else if (srst_r) begin
            swallow_r <= `SWALLOW_RESET; // see R03
            main_hi_r <= `MAIN_HI_RESET;
            main_lo_r <= `MAIN_LO_RESET;
            ref_loss_r <= `REF_LOSS_RESET;
            pump_r <= `PUMP_RESET;
        end else if (i_wr_stb) begin
            unique case (i_wr_addr)
                `ADDR_SWALLOW: begin
                    swallow_r <= i_wr_data & `SWALLOW_MASK; // see R07
                end
                `ADDR_MAIN_HI: begin
                    main_hi_r <= i_wr_data & `MAIN_HI_MASK; // see R08
                end
                `ADDR_MAIN_LO: begin
                    main_lo_r <= i_wr_data; // see R08
                end
                `ADDR_REF_LOSS: begin
                    ref_loss_r <= i_wr_data & `REF_LOSS_MASK; // see R09
                end
                `ADDR_PUMP: begin
                    pump_r <= i_wr_data & `PUMP_MASK; // see R11
                end
                default: begin
                end
            endcase
        end
    end

    // Field masks, restore and write capture of the PLL settings
    srst_rest_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R03
        srst_r |=> (main_hi_r == 8'h00 && ref_loss_r == 8'h00))
        else $error("soft reset left count or loss settings");
    pump_hi_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R11
        pump_r[7:2] == 6'h00)
        else $error("pump mode unused bits set");
    loss_unused_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R09
        (ref_loss_r & ~`REF_LOSS_MASK) == 8'h00)
        else $error("loss control unused bits set");
    swallow_wr_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R07
        (i_wr_stb && i_wr_addr == `ADDR_SWALLOW && !srst_r)
        |=> (swallow_r[5:0] == $past(i_wr_data[5:0])))
        else $error("swallow count write lost");
    main_lo_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R08
        (i_wr_stb && i_wr_addr == `ADDR_MAIN_LO && !srst_r)
        |=> (main_lo_r == $past(i_wr_data)))
        else $error("main count low write lost");

    // Read mux, unused addresses and bits read zero
    always_comb begin
        unique case (i_rd_addr)
            `ADDR_PORT_CFG: rd_nxt = cfg_r;
            `ADDR_SWALLOW: rd_nxt = swallow_r;
            `ADDR_MAIN_HI: rd_nxt = main_hi_r;
            `ADDR_MAIN_LO: rd_nxt = main_lo_r;
            `ADDR_REF_LOSS: rd_nxt = ref_loss_r;
            `ADDR_PUMP: rd_nxt = pump_r;
            default: rd_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rd_data <= 8'h00;
        end else begin
            o_rd_data <= rd_nxt;
        end
    end

    // Delay target in phase detector cycles
    always_comb begin
        unique case (ref_loss_r[6:5])
            2'b00: dly_target = `DLY_CODE0; // see R10
            2'b01: dly_target = `DLY_CODE1;
            2'b10: dly_target = `DLY_CODE2;
            2'b11: dly_target = `DLY_CODE3;
        endcase
    end

    // Loss detect armed after lock plus the chosen phase detector cycles
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            lock_seen_r <= 1'b0;
            dly_cnt_r <= 5'h00;
            det_en_r <= 1'b0;
        end else if (!ref_loss_r[`REF_LOSS_EN_BIT] || srst_r) begin
            lock_seen_r <= 1'b0; // see R09
            dly_cnt_r <= 5'h00;
            det_en_r <= 1'b0;
        end else if (!lock_seen_r) begin
            lock_seen_r <= lock_sync;
        end else if (!det_en_r && pd_rise) begin
            if (dly_cnt_r + 5'h01 >= dly_target) begin
                det_en_r <= 1'b1; // see R10
            end
            dly_cnt_r <= dly_cnt_r + 5'h01;
        end
    end

    // Loss detect only after lock, and it stays armed while enabled
    det_lock_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R10
        det_en_r |-> lock_seen_r)
        else $error("loss detect armed before lock");
    det_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R10
        (det_en_r && ref_loss_r[`REF_LOSS_EN_BIT] && !srst_r) |=> det_en_r)
        else $error("loss detect dropped while enabled");

    // Port mode outputs and pin drive
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            port_r <= '0;
            o_serial_out_pin <= 1'b0;
            o_serial_out_pin_oe <= 1'b0;
            o_sdio_out <= 1'b0;
            o_sdio_oe <= 1'b0;
        end else begin
            port_r.bidir <= cfg_r[`CFG_BIDIR_BIT];
            port_r.lsb_first <= cfg_r[`CFG_LSB_BIT]; // see R05
            port_r.long_instr <= cfg_r[`CFG_LONG_BIT]; // see R02
            o_serial_out_pin <= i_sdo_bit;
            o_serial_out_pin_oe <= i_sdo_req & ~cfg_r[`CFG_BIDIR_BIT]; // see R06
            o_sdio_out <= i_sdo_bit;
            o_sdio_oe <= i_sdo_req & cfg_r[`CFG_BIDIR_BIT]; // see R06
        end
    end

    // Only one data output drives, chosen by the bidirectional bit
    oe_excl_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R06
        !(o_serial_out_pin_oe && o_sdio_oe))
        else $error("both data outputs enabled");
    bidir_sdo_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R06
        port_r.bidir |-> !o_serial_out_pin_oe)
        else $error("serial out enabled in bidirectional mode");
    sdio_on_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R06
        ($past(cfg_r[`CFG_BIDIR_BIT]) && $past(i_sdo_req)) |-> o_sdio_oe)
        else $error("data pin not driven for read in bidirectional mode");

    // Registered configuration outputs
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_instr_len <= `INSTR_SHORT;
            o_lsb_first <= 1'b0;
            o_pll_cfg <= '0;
            o_ref_loss_detect_en <= 1'b0;
            o_soft_rst_busy <= 1'b0;
        end else begin
            o_instr_len <= port_r.long_instr ? `INSTR_LONG : `INSTR_SHORT; // see R02
            o_lsb_first <= port_r.lsb_first;
            o_pll_cfg.swallow <= swallow_r[5:0];
            o_pll_cfg.main_count <= {main_hi_r[4:0], main_lo_r};
            o_pll_cfg.ref_loss_en <= ref_loss_r[`REF_LOSS_EN_BIT];
            o_pll_cfg.ref_loss_delay <= ref_loss_r[6:5];
            o_pll_cfg.pump <= spll_pkg::pump_mode_type'(pump_r[1:0]); // see R11
            o_ref_loss_detect_en <= det_en_r;
            o_soft_rst_busy <= srst_r;
        end
    end

    // Outputs follow their registers one edge later
    busy_out_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R03
        srst_r |=> o_soft_rst_busy)
        else $error("soft reset busy not shown");
    pump_out_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R11
        o_pll_cfg.pump == $past(pump_r[1:0]))
        else $error("pump mode output wrong");
    main_out_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R08
        (o_pll_cfg.main_count[12:8] == $past(main_hi_r[4:0])
        && o_pll_cfg.main_count[7:0] == $past(main_lo_r)))
        else $error("main count output wrong");
    lsb_out_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R05
        o_lsb_first == $past(port_r.lsb_first))
        else $error("bit order output wrong");
    ilen_short_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R02
        !$past(port_r.long_instr) |-> (o_instr_len == `INSTR_SHORT))
        else $error("short instruction length wrong");

    // Checks
    cfg_now_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R01
        (i_wr_stb && i_wr_addr == `ADDR_PORT_CFG) |=> (cfg_r[7:6] == $past(i_wr_data[7:6])))
        else $error("port config write not applied");
    srst_clr_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R04
        (srst_r && !i_wr_stb) |=> !cfg_r[`CFG_SRST_BIT])
        else $error("soft reset bit did not clear");
    srst_def_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R03
        srst_r |=> (swallow_r == 8'h00 && pump_r == 8'h00 && main_lo_r == 8'h00))
        else $error("soft reset did not restore");
    swallow_hi_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R07
        swallow_r[7:6] == 2'b00)
        else $error("swallow upper bits set");
    main_hi_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R08
        main_hi_r[7:5] == 3'b000)
        else $error("main count high unused bits set");
    det_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R09
        !ref_loss_r[`REF_LOSS_EN_BIT] |=> !det_en_r)
        else $error("loss detect armed while disabled");
    det_cnt_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R10
        $rose(det_en_r) |-> (dly_cnt_r == dly_target))
        else $error("loss detect armed at wrong count");
    sdo_tri_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R06
        $past(cfg_r[`CFG_BIDIR_BIT]) |-> !o_serial_out_pin_oe)
        else $error("serial out driven in bidirectional mode");
    ilen_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R02
        $past(port_r.long_instr) |-> (o_instr_len == `INSTR_LONG))
        else $error("instruction length wrong");
endmodule
`default_nettype wire

// >>> spll_regs.svh
`ifndef SPLL_REGS_SVH
`define SPLL_REGS_SVH
// Register offsets
`define ADDR_PORT_CFG 13'h0000
`define ADDR_SWALLOW 13'h0004
`define ADDR_MAIN_HI 13'h0005
`define ADDR_MAIN_LO 13'h0006
`define ADDR_REF_LOSS 13'h0007
`define ADDR_PUMP 13'h0008
// Port configuration fields
`define CFG_LONG_BIT 4
`define CFG_SRST_BIT 5
`define CFG_LSB_BIT 6
`define CFG_BIDIR_BIT 7
// Reset values
`define CFG_RESET 8'h00
`define SWALLOW_RESET 8'h00
`define MAIN_HI_RESET 8'h00
`define MAIN_LO_RESET 8'h00
`define REF_LOSS_RESET 8'h00
`define PUMP_RESET 8'h00
// Field masks
`define SWALLOW_MASK 8'h3F
`define MAIN_HI_MASK 8'h1F
`define REF_LOSS_MASK 8'h64
`define PUMP_MASK 8'h03
`define REF_LOSS_EN_BIT 2
// Phase detector cycle counts for the loss detect delay
`define DLY_CODE0 5'h03
`define DLY_CODE1 5'h06
`define DLY_CODE2 5'h0C
`define DLY_CODE3 5'h18
// Instruction lengths in bits
`define INSTR_SHORT 5'h08
`define INSTR_LONG 5'h10
`endif

// >>> spll_pkg.sv
package spll_pkg;
    typedef enum logic [1:0] {
        PUMP_TRISTATE,
        PUMP_UP,
        PUMP_DOWN,
        PUMP_NORMAL
    } pump_mode_type;
    typedef struct packed {
        logic [5:0] swallow;
        logic [12:0] main_count;
        logic ref_loss_en;
        logic [1:0] ref_loss_delay;
        pump_mode_type pump;
    } pll_cfg_type;
    typedef struct packed {
        logic bidir;
        logic lsb_first;
        logic long_instr;
    } port_cfg_type;
endpackage

// >>> edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser with rise and fall detection on the second stage
module edge_sync (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_async,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // Synchroniser chain
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Edge outputs from stable stages only
    assign o_level = sync_r;
    assign o_rise = sync_r & ~prev_r;
    assign o_fall = ~sync_r & prev_r;
endmodule
`default_nettype wire

// >>> spll_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host side: drives byte writes, read addresses and phase detector pulses
module spll_host (
    input wire logic i_sys_clk,
    output logic o_wr_stb,
    output logic [12:0] o_wr_addr,
    output logic [7:0] o_wr_data,
    output logic [12:0] o_rd_addr,
    output logic o_rd_seen,
    output logic o_pd_clk
);
    // Idle values at time zero
    initial begin
        o_wr_stb = 1'b0;
        o_wr_addr = 13'h1FFF;
        o_wr_data = 8'h00;
        o_rd_addr = 13'h0000;
        o_rd_seen = 1'b0;
        o_pd_clk = 1'b0;
    end
    // One-cycle write; fields scrambled once the strobe drops
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge i_sys_clk) #1;
        o_wr_stb = 1'b1;
        o_wr_addr = a;
        o_wr_data = d;
        @(posedge i_sys_clk) #1;
        o_wr_stb = 1'b0;
        o_wr_addr = ~a;
        o_wr_data = ~d;
    endtask
    // Address held until the returned byte has been looked at
    task automatic rd(input logic [12:0] a);
        @(posedge i_sys_clk) #1;
        o_rd_addr = a;
        @(posedge i_sys_clk) #1;
        o_rd_seen = 1'b1;
        @(posedge i_sys_clk) #1;
        o_rd_seen = 1'b0;
    endtask
    // Phase detector clock only runs while a burst is asked for
    task automatic pd(input int n);
        repeat (n) begin
            o_pd_clk = 1'b1;
            #160;
            o_pd_clk = 1'b0;
            #160;
        end
    endtask
endmodule
`default_nettype wire

// >>> tb_spll_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_spll_ctrl;
    logic i_sys_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic lock = 1'b0;
    logic sdo_req = 1'b0;
    logic sdo_bit = 1'b0;
    logic wr_stb, rd_seen, pd_clk, sop, sop_oe, sdio_out, sdio_oe, lor_en, busy;
    logic busy_seen = 1'b0;
    logic [12:0] wr_addr, rd_addr;
    logic [7:0] wr_data, rd_data, d;
    logic [4:0] instr_len;
    logic lsb_first;
    spll_pkg::pll_cfg_type cfg;
    int fail_count = 0;
    int comparisons = 0;
    int seed = 32'h6e52;
    logic [7:0] exp_q[$];
    logic [7:0] mask [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h1F, 8'hFF, 8'h64, 8'h03};
    int dly [4] = '{3, 6, 12, 24};

    // 25 MHz system clock
    always #20 i_sys_clk = ~i_sys_clk;

    spll_host i_host (.i_sys_clk(i_sys_clk), .o_wr_stb(wr_stb), .o_wr_addr(wr_addr),
        .o_wr_data(wr_data), .o_rd_addr(rd_addr), .o_rd_seen(rd_seen), .o_pd_clk(pd_clk));

    spll_ctrl i_dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_wr_stb(wr_stb),
        .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_rd_addr(rd_addr), .i_pd_clk(pd_clk),
        .i_lock(lock), .i_sdo_req(sdo_req), .i_sdo_bit(sdo_bit), .o_rd_data(rd_data),
        .o_instr_len(instr_len), .o_lsb_first(lsb_first), .o_serial_out_pin(sop),
        .o_serial_out_pin_oe(sop_oe), .o_sdio_out(sdio_out), .o_sdio_oe(sdio_oe),
        .o_pll_cfg(cfg), .o_ref_loss_detect_en(lor_en), .o_soft_rst_busy(busy));

    // Compare and count
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Note the expected byte, then read it
    task automatic rd_exp(input logic [12:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_host.rd(a);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Read data monitor takes the oldest note
    always @(negedge i_sys_clk) begin
        if (rd_seen === 1'b1) begin
            check("rd_data", rd_data, exp_q.pop_front());
        end
    end

    // Catch the soft reset pulse
    always @(posedge i_sys_clk) begin
        if (busy === 1'b1) begin
            busy_seen <= 1'b1;
        end
    end

    // Watchdog
    initial begin
        #400000;
        fail_count++;
        final_report();
    end

    // Test sequence
    initial begin
        repeat (16) @(posedge i_sys_clk);
        #1;
        i_resetn = 1'b1;
        for (int a = 0; a < 9; a++) rd_exp(a, 8'h00);
        check("instr_len", instr_len, 16'h0008);
        $display("test reset values done");
        // All ones to addresses 1 to 8, unused bits and unmapped place stay clear
        for (int a = 1; a < 9; a++) i_host.wr(a, 8'hFF);
        i_host.wr(13'h1004, 8'h00);
        for (int a = 1; a < 9; a++) rd_exp(a, mask[a]);
        check("main_count", cfg.main_count, 16'h1FFF);
        check("ref_loss_en", cfg.ref_loss_en, 16'h0001);
        $display("test masks done");
        // Random counts with every pump mode
        for (int m = 0; m < 4; m++) begin
            d = 8'($random(seed));
            i_host.wr(4, d);
            i_host.wr(6, d);
            i_host.wr(8, 8'(m));
            wait_n(2);
            check("swallow", cfg.swallow, {10'h000, d[5:0]});
            check("main_count", cfg.main_count, {3'h0, 5'h1F, d});
            check("pump", cfg.pump, 16'(m));
        end
        $display("test counts done");
        // Port config takes effect at once
        i_host.wr(0, 8'h5F);
        wait_n(2);
        check("instr_len", instr_len, 16'h0010);
        check("lsb_first", lsb_first, 16'h0001);
        rd_exp(0, 8'h50);
        sdo_req = 1'b1;
        sdo_bit = 1'($random(seed));
        wait_n(2);
        check("sop_oe", {sop_oe, sdio_oe}, 16'h0002);
        check("sop", sop, 16'(sdo_bit));
        sdo_bit = 1'($random(seed));
        i_host.wr(0, 8'hD0);
        wait_n(2);
        check("sdio_oe", {sop_oe, sdio_oe}, 16'h0001);
        check("sdio_out", sdio_out, 16'(sdo_bit));
        sdo_req = 1'b0;
        $display("test port config done");
        // Soft reset restores the others and clears itself
        i_host.wr(0, 8'hF0);
        wait_n(4);
        check("busy_seen", busy_seen, 16'h0001);
        check("oe_idle", {sop_oe, sdio_oe}, 16'h0000);
        rd_exp(0, 8'hD0);
        for (int a = 4; a < 9; a++) rd_exp(a, 8'h00);
        $display("test soft reset done");
        // Loss detect arms on the chosen phase detector edge
        for (int c = 0; c < 4; c++) begin
            lock = 1'b0;
            i_host.wr(7, 8'h00);
            i_host.wr(7, {1'b0, 2'(c), 5'h04});
            lock = 1'b1;
            wait_n(4);
            check("lor_delay", cfg.ref_loss_delay, 16'(c));
            i_host.pd(dly[c] - 1);
            check("lor_early", lor_en, 16'h0000);
            i_host.pd(1);
            wait_n(2);
            check("lor_armed", lor_en, 16'h0001);
        end
        i_host.wr(7, 8'h60);
        wait_n(3);
        check("lor_off", lor_en, 16'h0000);
        $display("test loss detect done");
        final_report();
    end
endmodule
`default_nettype wire
